// *** rtl/byte_rotate_execution_unit.sv ***
// Byte rotate execution unit: runs the plain right rotate over four quarters.
// Assumes the file register array answers a read combinationally on rd_data_i
// for the address held on file_addr_o, and writes on file_we_o.
//
// How it works
// - Opcode 0100 00da rotates right plainly
// - d=0 writes W, d=1 writes file
// - a=0 access bank, a=1 bank select
// - Extended, a=0, f<=5Fh uses indexed offset
`timescale 1ns/1ps
module byte_rotate_execution_unit
    import byte_rotate_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic             instr_valid_i,
    input  wire logic [15:0]      instr_i,
    input  wire logic [3:0]       bank_select_register_i,
    input  wire logic             ext_set_enable_i,
    input  wire logic [11:0]      index_base_i,
    input  wire logic [WIDTH-1:0] rd_data_i,
    output logic      [11:0]      file_addr_o,
    output logic                  file_we_o,
    output logic      [WIDTH-1:0] file_wdata_o,
    output logic      [WIDTH-1:0] wreg_o,
    output logic                  neg_flag_o,
    output logic                  zero_flag_o,
    output logic                  flag_we_o,
    output logic                  busy_o,
    output logic                  done_o
);
    import byte_rotate_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic is_rotate_plain(input logic [15:0] op);
        return (op[OP_TOP_MSB -: 4] == OP_TOP_ROTATE) && (op[OP_SUB_MSB -: 2] == OP_SUB_RR_PLAIN);
    endfunction : is_rotate_plain

    function automatic logic [11:0] effective_addr(input logic [15:0] op, input logic [3:0] bank,
                                                   input logic ext, input logic [11:0] base);
        logic [7:0] f;
        f = op[7:0];
        if (op[OP_ACCESS_BIT]) begin
            effective_addr = {bank, f};
        end else if (ext && (f <= INDEXED_LIMIT)) begin
            effective_addr = base + {4'h0, f};
        end else if (f < ACCESS_SPLIT) begin
            effective_addr = {ACCESS_LOW_BANK, f};
        end else begin
            effective_addr = {ACCESS_HI_BANK, f};
        end
    endfunction : effective_addr

    quarter_t          phase_r;
    logic              dest_r;
    logic              active_r;
    logic [WIDTH-1:0]  operand_r;
    logic [WIDTH-1:0]  result_r;
    logic [WIDTH-1:0]  alu_res;
    logic              alu_neg;
    logic              alu_zero;
    logic              neg_r;
    logic              zero_r;

    rotate_alu #(.WIDTH(WIDTH)) u_alu (
        .operand_i (operand_r),
        .result_o  (alu_res),
        .neg_o     (alu_neg),
        .zero_o    (alu_zero)
    );

    // ==========================================================
    // Quarter sequencer
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_r  <= Q1_DECODE;
            active_r <= 1'b0;
            busy_o   <= 1'b0;
        end else begin
            case (phase_r)
                Q1_DECODE: begin
                    if (instr_valid_i && is_rotate_plain(instr_i)) begin
                        phase_r  <= Q2_READ;
                        active_r <= 1'b1;
                        busy_o   <= 1'b1;
                    end
                end
                Q2_READ:    phase_r <= Q3_PROCESS;
                Q3_PROCESS: phase_r <= Q4_WRITE;
                Q4_WRITE: begin
                    phase_r  <= Q1_DECODE;
                    active_r <= 1'b0;
                    busy_o   <= 1'b0;
                end
                default:    phase_r <= Q1_DECODE;
            endcase
        end
    end

    // ==========================================================
    // Bank and indexed address capture at decode
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            file_addr_o <= ADDR_RESET;
            dest_r      <= 1'b1;
        end else if (phase_r == Q1_DECODE && instr_valid_i && is_rotate_plain(instr_i)) begin
            file_addr_o <= effective_addr(instr_i, bank_select_register_i, ext_set_enable_i, index_base_i);
            dest_r      <= instr_i[OP_DEST_BIT];
        end
    end

    // ==========================================================
    // Read, then process
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operand_r <= '0;
            result_r  <= '0;
            neg_r     <= 1'b0;
            zero_r    <= 1'b0;
        end else begin
            if (phase_r == Q2_READ) begin
                operand_r <= rd_data_i;
            end
            if (phase_r == Q3_PROCESS) begin
                result_r <= alu_res;
                neg_r    <= alu_neg;
                zero_r   <= alu_zero;
            end
        end
    end

    // ==========================================================
    // Destination write in the last quarter
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wreg_o       <= WREG_RESET;
            file_we_o    <= 1'b0;
            file_wdata_o <= '0;
            neg_flag_o   <= 1'b0;
            zero_flag_o  <= 1'b0;
            flag_we_o    <= 1'b0;
            done_o       <= 1'b0;
        end else begin
            file_we_o <= 1'b0;
            flag_we_o <= 1'b0;
            done_o    <= 1'b0;
            if (phase_r == Q4_WRITE) begin
                if (dest_r) begin
                    file_we_o    <= 1'b1;
                    file_wdata_o <= result_r;
                end else begin
                    wreg_o <= result_r;
                end
                neg_flag_o  <= neg_r;
                zero_flag_o <= zero_r;
                flag_we_o   <= 1'b1;
                done_o      <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_start;
        phase_r == Q1_DECODE && instr_valid_i && is_rotate_plain(instr_i);
    endsequence

    chk_cycle_length: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start |-> ##4 done_o) else $error("rotate did not finish in four quarters");

    // Starts one edge late: a back-to-back accept still sees the last done
    chk_no_early_done: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start |=> !done_o[*3]) else $error("done asserted early");

    chk_rotate_value: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        phase_r == Q3_PROCESS |=> result_r == {$past(operand_r[0]), $past(operand_r[WIDTH-1:1])})
        else $error("rotate result wrong");

    chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        done_o |-> zero_flag_o == (file_wdata_o == '0 && dest_r || wreg_o == '0 && !dest_r))
        else $error("zero flag mismatch");

    chk_dest_file: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start ##0 instr_i[OP_DEST_BIT] |-> ##4 file_we_o) else $error("file write missing");

    chk_dest_wreg: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start ##0 !instr_i[OP_DEST_BIT] |-> ##4 !file_we_o) else $error("file written for W dest");

    chk_bank_select: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start ##0 instr_i[OP_ACCESS_BIT] |=> file_addr_o == {$past(bank_select_register_i), $past(instr_i[7:0])})
        else $error("bank select not used");

    chk_indexed_mode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start ##0 !instr_i[OP_ACCESS_BIT] && ext_set_enable_i && instr_i[7:0] <= INDEXED_LIMIT
        |=> file_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
        else $error("indexed address wrong");

    chk_access_split: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start ##0 !instr_i[OP_ACCESS_BIT] && !(ext_set_enable_i && instr_i[7:0] <= INDEXED_LIMIT)
        |=> file_addr_o[7:0] == $past(instr_i[7:0])
            && file_addr_o[11:8] == ((file_addr_o[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HI_BANK))
        else $error("access bank address wrong");

    sequence s_busy_run;
        busy_o[*3] ##1 !busy_o;
    endsequence

    chk_busy_span: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_start |=> s_busy_run) else $error("busy span wrong");

    chk_wreg_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        done_o && !dest_r |-> wreg_o == $past(result_r)) else $error("W not written");

    chk_wreg_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        done_o && dest_r |-> wreg_o == $past(wreg_o) && file_wdata_o == $past(result_r))
        else $error("W changed for file dest");

    chk_neg_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        done_o |-> neg_flag_o == $past(result_r[WIDTH-1])) else $error("negative flag mismatch");

    // Other opcodes must never start the sequencer
    chk_ignore_other: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        phase_r == Q1_DECODE && !(instr_valid_i && is_rotate_plain(instr_i)) |=> !busy_o)
        else $error("foreign opcode accepted");

endmodule : byte_rotate_execution_unit

// *** rtl/byte_rotate_pkg.sv ***
// Constants for the byte rotate execution unit.
// Assumes an 8-bit core with a 12-bit data address (4-bit bank, 8-bit offset).
package byte_rotate_pkg;

    // ==========================================================
    // Opcode fields
    localparam logic [3:0] OP_TOP_ROTATE   = 4'h4;
    localparam logic [1:0] OP_SUB_RR_PLAIN = 2'h0;
    localparam int         OP_TOP_MSB      = 15;
    localparam int         OP_SUB_MSB      = 11;
    localparam int         OP_DEST_BIT     = 9;
    localparam int         OP_ACCESS_BIT   = 8;

    // ==========================================================
    // Addressing
    localparam logic [7:0] INDEXED_LIMIT   = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  WREG_RESET  = 8'h00;
    localparam logic [1:0]  PHASE_RESET = 2'h0;
    localparam logic [11:0] ADDR_RESET  = 12'h000;

    // Quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        Q1_DECODE,
        Q2_READ,
        Q3_PROCESS,
        Q4_WRITE
    } quarter_t;

endpackage : byte_rotate_pkg

// *** rtl/rotate_alu.sv ***
// Combinational rotate-right-plain datapath with flag generation.
// Assumes the caller registers every output it needs.
`timescale 1ns/1ps
module rotate_alu #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] operand_i,
    output logic      [WIDTH-1:0] result_o,
    output logic                  neg_o,
    output logic                  zero_o
);
    assign result_o = {operand_i[0], operand_i[WIDTH-1:1]};
    assign neg_o    = result_o[WIDTH-1];
    assign zero_o   = (result_o == '0);
endmodule : rotate_alu

// *** tb/testbench.sv ***
// Self-checking bench for the byte rotate execution unit.
// Assumes the bench plays both the core sequencer and the file register array.
`timescale 1ns/1ps
module testbench;
    import byte_rotate_pkg::*;
    logic        sys_clk_i = 0, reset_i = 1, instr_valid_i = 0, ext_set_enable_i = 0;
    logic [15:0] instr_i = '0;
    logic [3:0]  bank_select_register_i = '0;
    logic [11:0] index_base_i = '0, file_addr_o;
    logic [7:0]  rd_data_i = '0, file_wdata_o, wreg_o;
    logic        file_we_o, neg_flag_o, zero_flag_o, flag_we_o, busy_o, done_o, busy_q = 0;
    logic [32:0] notes[$];
    logic [32:0] got, exp;
    logic [34:0] rst_got;
    logic [7:0]  w_model = WREG_RESET;
    int          miscompares = 0, checks = 0, cycles = 0, since = 0;

    byte_rotate_execution_unit u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .bank_select_register_i(bank_select_register_i), .ext_set_enable_i(ext_set_enable_i),
        .index_base_i(index_base_i), .rd_data_i(rd_data_i), .file_addr_o(file_addr_o), .file_we_o(file_we_o),
        .file_wdata_o(file_wdata_o), .wreg_o(wreg_o), .neg_flag_o(neg_flag_o), .zero_flag_o(zero_flag_o),
        .flag_we_o(flag_we_o), .busy_o(busy_o), .done_o(done_o));

    always #20 sys_clk_i = ~sys_clk_i;

    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // ==========================================================
    // Issue one rotate; held until an edge finds the unit idle, then one
    // edge more so the operand read still sees this call's data
    task send(input logic d, input logic a, input logic e, input logic [7:0] f, input logic [7:0] v);
        logic [3:0]  b;
        logic [11:0] x, ad;
        logic [7:0]  r;
        logic        free;
        int          n;
        b = 4'($urandom);
        x = 12'($urandom);
        r = {v[0], v[7:1]};
        if (a)
            ad = {b, f};
        else if (e && f <= INDEXED_LIMIT)
            ad = x + {4'h0, f};
        else
            ad = {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HI_BANK, f};
        if (!d)
            w_model = r;
        notes.push_back({ad, d, r, r[7], r == 8'h00, 1'b1, 1'b1, w_model});
        instr_valid_i <= 1'b1;
        instr_i <= {OP_TOP_ROTATE, OP_SUB_RR_PLAIN, d, a, f};
        bank_select_register_i <= b;
        ext_set_enable_i <= e;
        index_base_i <= x;
        rd_data_i <= v;
        n = 0;
        do begin
            #1;
            free = (busy_o === 1'b0);
            @(posedge sys_clk_i);
            n++;
        end while (!free && n < 20);
        @(posedge sys_clk_i);
    endtask : send

    // Opcodes outside the plain right rotate must stay silent
    task junk(input logic [15:0] w);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        repeat (6) @(posedge sys_clk_i);
    endtask : junk

    // ==========================================================
    // Result watcher
    always begin
        @(posedge sys_clk_i);
        #1;
        since = (busy_o === 1'b1 && busy_q !== 1'b1) ? 0 : since + 1;
        busy_q = busy_o;
        if (done_o === 1'b1) begin
            exp = notes.size() ? notes.pop_front() : 'x;
            got = {file_addr_o, file_we_o, exp[20] ? file_wdata_o : wreg_o, neg_flag_o, zero_flag_o, flag_we_o,
                   since == 3, wreg_o};
            checks++;
            if (got !== exp) begin
                $display("unexpected at %0t got %h exp %h", $time, got, exp);
                miscompares++;
            end
        end
    end

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'h6844dc6a));
        repeat (4) @(posedge sys_clk_i);
        #1;
        rst_got = {file_addr_o, file_we_o, file_wdata_o, wreg_o, neg_flag_o, zero_flag_o, flag_we_o, busy_o, done_o};
        checks++;
        if (rst_got !== {ADDR_RESET, 1'b0, 8'h00, WREG_RESET, 6'h00}) begin
            $display("unexpected at %0t got %h exp %h", $time, rst_got, {ADDR_RESET, 1'b0, 8'h00, WREG_RESET, 6'h00});
            miscompares++;
        end
        @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        // indexed boundary, access bank split, bank select, two foreign opcodes
        send(1'b0, 1'b0, 1'b1, 8'h5f, 8'h01);
        send(1'b1, 1'b0, 1'b1, 8'h60, 8'h80);
        send(1'b1, 1'b0, 1'b0, 8'h10, 8'h00);
        send(1'b0, 1'b1, 1'b1, 8'h20, 8'hd7);
        junk({OP_TOP_ROTATE, 2'h1, 10'h155});
        junk(16'h3123);
        for (int i = 0; i < 80; i++) begin
            send(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
            if (i % 16 == 15)
                junk({4'($urandom) & 4'hb, 12'($urandom)});
        end
        instr_valid_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        if (notes.size() != 0) begin
            $display("unexpected at %0t got %h exp %h", $time, notes.size(), 0);
            miscompares++;
        end
        conclude();
    end
endmodule : testbench
